// *** logic/ifb_top.sv ***
// Interrupt request flag and enable register bank with vector selection.
// Assumes the core reads and writes the bank as data memory, pulses
// i_irq_ack when it takes the presented vector, and peripherals pulse
// their request lines for one clock.
`timescale 1ns/10ps
`include "ifb_defs.svh"

module ifb_top
(
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   // Data memory access to the registers
   input  wire logic [3:0]              i_sfr_sel,
   input  wire logic                    i_sfr_wr,
   input  wire logic [7:0]              i_sfr_wdata,
   output logic      [7:0]              o_sfr_rdata,
   // Request sources
   input  wire logic [`IFB_NPIN-1:0]    i_ext_edge_pins,
   input  wire ifb_pkg::ifb_src_t       i_src,
   // Core side
   input  wire logic                    i_irq_ack,
   output logic                         o_irq_req,
   output ifb_pkg::ifb_vec_t            o_irq_vec
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ifb_pkg::ifb_state_t      st_reg;            // Registered state
   ifb_pkg::ifb_state_t      st_next;           // Next state
   logic [`IFB_NPIN-1:0]     ext_hit;           // Qualified pin edges
   logic [`IFB_NGRP-1:0][3:0] grp_ev;           // Member events per group
   logic [`IFB_NGRP-1:0]     grp_set;           // Group flag set events
   logic [`IFB_NVEC-1:0]     prim_ev;           // Primary flag set events
   logic [`IFB_NVEC-1:0]     pend_next;         // Pending after update
   logic [`IFB_NVEC-1:0]     pend_cur;          // Pending now, for checks
   logic [5:0]               loc;               // Register and bit of a vector
   logic [5:0]               set_loc;           // Register and bit of a set event
   logic                     found;             // Priority search hit

   ////////////////////////////////////////////////////////////////////////
   // Where each vector keeps its enable; flag_of gives its flag bit
   function automatic logic [5:0] loc_of(input logic [3:0] v);
      logic [5:0] r;
      r = {`IFB_REG_PA, 2'h1};
      unique case (v)
         ifb_pkg::IFB_V_INT0: r = {`IFB_REG_PA, 2'h1};
         ifb_pkg::IFB_V_INT1: r = {`IFB_REG_PA, 2'h2};
         ifb_pkg::IFB_V_INT2: r = {`IFB_REG_PD, 2'h0};
         ifb_pkg::IFB_V_INT3: r = {`IFB_REG_PD, 2'h1};
         ifb_pkg::IFB_V_CP0:  r = {`IFB_REG_PA, 2'h3};
         ifb_pkg::IFB_V_CP1:  r = {`IFB_REG_PB, 2'h0};
         ifb_pkg::IFB_V_MF0:  r = {`IFB_REG_PB, 2'h1};
         ifb_pkg::IFB_V_MF1:  r = {`IFB_REG_PB, 2'h2};
         ifb_pkg::IFB_V_MF2:  r = {`IFB_REG_PC, 2'h0};
         ifb_pkg::IFB_V_MF3:  r = {`IFB_REG_PC, 2'h3};
         ifb_pkg::IFB_V_MF4:  r = {`IFB_REG_PD, 2'h2};
         ifb_pkg::IFB_V_ADC:  r = {`IFB_REG_PB, 2'h3};
         ifb_pkg::IFB_V_TB0:  r = {`IFB_REG_PC, 2'h1};
         ifb_pkg::IFB_V_TB1:  r = {`IFB_REG_PC, 2'h2};
         // Codes 14 and 15 are never presented
         default:             r = {`IFB_REG_PA, 2'h1};
      endcase
      return r;
   endfunction

   // Flag bit of a vector. The first primary register carries the global
   // enable at bit 0, so its flags sit only three above their enables;
   // a plain four-bit offset there would hit another vector's flag or bit 7
   function automatic logic [2:0] flag_of(input logic [5:0] l);
      logic [2:0] f;
      f = {`IFB_FLAG_OFS, l[1:0]};
      if (l[5:2] == `IFB_REG_PA)
      begin
         f = {1'b0, l[1:0]} + `IFB_FLAG_OFS_PA;
      end
      return f;
   endfunction

   // Write mask; unimplemented bits cannot be set
   function automatic logic [7:0] mask_of(input logic [3:0] idx);
      logic [7:0] m;
      m = `IFB_MASK_FULL;
      if (idx == `IFB_REG_PA)
      begin
         m = `IFB_MASK_PA;
      end
      else if (idx == `IFB_REG_PD || idx == 4'h6 || idx == 4'h8)
      begin
         m = `IFB_MASK_GAP;
      end
      return m;
   endfunction

   // Enabled and flagged vectors of a register image
   function automatic logic [`IFB_NVEC-1:0] pend_of(input ifb_pkg::ifb_regs_t r);
      logic [`IFB_NVEC-1:0] p;
      logic [5:0]           l;
      p = '0;
      for (int v = 0; v < `IFB_NVEC; v++)
      begin
         l    = loc_of(4'(v));
         p[v] = r[l[5:2]][{1'b0, l[1:0]}] & r[l[5:2]][flag_of(l)];
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // External pin edges, synchronised inside
   ifb_edge_det u_edge
   (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_pins  (i_ext_edge_pins),
      .i_sel   (st_reg.regs[`IFB_REG_EDGE]),
      .o_hit   (ext_hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Member events aligned to their enable bits in each group register
   always_comb
   begin
      grp_ev[0] = {i_src.tmr_a[2], i_src.tmr_p[2], i_src.tmr_a[0], i_src.tmr_p[0]};
      grp_ev[1] = {1'b0, i_src.tmr1_b, i_src.tmr_a[1], i_src.tmr_p[1]};
      grp_ev[2] = {i_src.serial, i_src.port_change, i_src.tmr_a[3], i_src.tmr_p[3]};
      grp_ev[3] = {1'b0, i_src.second_serial, i_src.eeprom, i_src.volt};
      grp_ev[4] = {i_src.tmr_a[5], i_src.tmr_p[5], i_src.tmr_a[4], i_src.tmr_p[4]};
   end

   // Group flag set: a member event whose own enable is one
   always_comb
   begin
      for (int g = 0; g < `IFB_NGRP; g++)
      begin
         grp_set[g] = |(grp_ev[g] & st_reg.regs[`IFB_REG_GA + 4'(g)][3:0]);
      end
   end

   // Primary set events in vector order
   always_comb
   begin
      prim_ev = {i_src.time_base, i_src.conv_done, grp_set, i_src.cmp, ext_hit};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: write, then service clear, then hardware sets, so a
   // request in the clearing cycle is never lost
   always_comb
   begin
      st_next   = st_reg;
      loc       = loc_of(st_reg.irq_vec);
      found     = 1'b0;
      set_loc   = 6'h00;

      if (i_sfr_sel <= `IFB_REG_GE)
      begin
         st_next.rdata = st_reg.regs[i_sfr_sel];
      end
      else
      begin
         // Unmapped index reads zero
         st_next.rdata = 8'h00;
      end

      if (i_sfr_wr && i_sfr_sel <= `IFB_REG_GE)
      begin
         st_next.regs[i_sfr_sel] = i_sfr_wdata & mask_of(i_sfr_sel);
      end

      // Service taken: clear the served flag and the global enable
      if (i_irq_ack)
      begin
         st_next.regs[loc[5:2]][flag_of(loc)] = 1'b0;
         st_next.regs[`IFB_REG_PA][`IFB_EMI_BIT] = 1'b0;
      end

      // Member flags in group registers; only software clears them
      for (int g = 0; g < `IFB_NGRP; g++)
      begin
         st_next.regs[`IFB_REG_GA + 4'(g)][7:4] =
            st_next.regs[`IFB_REG_GA + 4'(g)][7:4] | grp_ev[g];
      end
      // Gap positions of group b and d have no source
      st_next.regs[4'h6][7] = 1'b0;
      st_next.regs[4'h8][7] = 1'b0;

      // Primary flags; set wins over a clear in the same cycle
      for (int v = 0; v < `IFB_NVEC; v++)
      begin
         if (prim_ev[v])
         begin
            set_loc = loc_of(4'(v));
            st_next.regs[set_loc[5:2]][flag_of(set_loc)] = 1'b1;
         end
      end

      // Lowest pending vector is presented
      pend_next = pend_of(st_next.regs);
      for (int v = 0; v < `IFB_NVEC; v++)
      begin
         if (pend_next[v] && !found)
         begin
            found           = 1'b1;
            st_next.irq_vec = ifb_pkg::ifb_vec_t'(4'(v));
         end
      end

      st_next.irq_req = st_next.regs[`IFB_REG_PA][`IFB_EMI_BIT] & found;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; all registers clear at reset
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_sfr_rdata = st_reg.rdata;
   assign o_irq_req   = st_reg.irq_req;
   assign o_irq_vec   = st_reg.irq_vec;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   assign pend_cur = pend_of(st_reg.regs);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   // No request may reach the core while the global enable is clear
   property p_req_needs_emi;
      o_irq_req |-> st_reg.regs[`IFB_REG_PA][0];
   endproperty
   a_req_needs_emi: assert property (p_req_needs_emi)
      else $error("request raised with global enable clear");

   // Service of time base 1 drops its flag, the global enable and the request
   property p_ack_clears;
      (i_irq_ack && o_irq_vec == ifb_pkg::IFB_V_TB1 && !i_src.time_base[1])
      |=> !st_reg.regs[`IFB_REG_PC][6] && !st_reg.regs[`IFB_REG_PA][0] && !o_irq_req;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("service did not clear flag and global enable");

   // Member flags survive service of their group; new events may still set
   property p_member_stays;
      (i_irq_ack && o_irq_vec == ifb_pkg::IFB_V_MF0 && !i_sfr_wr && grp_ev[0] == 4'h0)
      |=> st_reg.regs[`IFB_REG_GA][7:4] == $past(st_reg.regs[`IFB_REG_GA][7:4]);
   endproperty
   a_member_stays: assert property (p_member_stays)
      else $error("group member flags changed on service");

   // An enabled member event raises the group flag one cycle later
   property p_group_set;
      (|(grp_ev[0] & st_reg.regs[`IFB_REG_GA][3:0])) |=> st_reg.regs[`IFB_REG_PB][5];
   endproperty
   a_group_set: assert property (p_group_set)
      else $error("enabled member event did not set group flag");

   // A hardware set is never lost to a software write in the same cycle
   property p_set_wins;
      (i_src.time_base[0] && i_sfr_wr && i_sfr_sel == `IFB_REG_PC)
      |=> st_reg.regs[`IFB_REG_PC][5];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("time base event lost to a software write");

   // Pin 3 edge lands on its flag in the fourth primary register
   property p_pin_flag;
      ext_hit[3] |=> st_reg.regs[`IFB_REG_PD][5];
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin 3 edge did not set its flag");

   // Pin 0 edge lands on bit 4, three above its enable
   property p_pin0_flag;
      ext_hit[0] |=> st_reg.regs[`IFB_REG_PA][4];
   endproperty
   a_pin0_flag: assert property (p_pin0_flag)
      else $error("pin 0 edge did not set its flag");

   // Comparator 0 change lands on bit 6 of the first primary register
   property p_cmp0_flag;
      i_src.cmp[0] |=> st_reg.regs[`IFB_REG_PA][6];
   endproperty
   a_cmp0_flag: assert property (p_cmp0_flag)
      else $error("comparator 0 event did not set its flag");

   // Unimplemented bits never hold a one, whatever software writes
   property p_gaps_zero;
      !st_reg.regs[`IFB_REG_PA][7] && !st_reg.regs[`IFB_REG_PD][7] &&
      !st_reg.regs[`IFB_REG_PD][3] && !st_reg.regs[4'h6][7] && !st_reg.regs[4'h8][3];
   endproperty
   a_gaps_zero: assert property (p_gaps_zero)
      else $error("unimplemented bit holds a one");

   // The presented vector is pending and nothing lower is
   property p_priority;
      o_irq_req |-> (pend_cur & ((14'h0001 << o_irq_vec) - 14'h0001)) == 14'h0000
                    && pend_cur[o_irq_vec];
   endproperty
   a_priority: assert property (p_priority)
      else $error("presented vector is not the lowest pending");

   // Read data shows the selected register one cycle later
   property p_read_back;
      (i_sfr_sel == `IFB_REG_PB) |=> o_sfr_rdata == $past(st_reg.regs[`IFB_REG_PB]);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read data does not match register");

   c_ack:      cover property (i_irq_ack && o_irq_req);
   c_group:    cover property (grp_set[2] ##1 o_irq_vec == ifb_pkg::IFB_V_MF2);
   c_pin_rise: cover property (ext_hit[0] ##1 o_irq_req);
   c_two_pend: cover property (o_irq_req && $countones(pend_cur) > 1);

endmodule

// *** logic/ifb_defs.svh ***
// Constants of the interrupt flag and enable bank: register indices,
// bit positions, write masks and reset values.
// Assumes inclusion by bare name from the package and the design files.
//
// Behaviour
// - Two-bit edge code: off, rise, fall, both
// - Four pin selectors packed in one edge register
// - Flag one means pending; enable one permits
// - Hardware sets flags; software writes enables
// - Global enable at bit 0 gates servicing
// - First primary register bit layout, bit 7 empty
// - Second primary: converter, groups 0-1, comparator 1
// - Third primary: groups 2-3, time bases 0-1
// - Fourth primary: group 4, pins 2-3, gaps zero
// - First group register: timers 0 and 2
// - Second group: timer 1 B, A, P
// - Third group: serial, port change, timer 3
// - Accept pin, port-change and internal peripheral requests
// - Primary, group and edge registers organise control
// - Registers reached by ordinary data reads, writes
// - Accepted request suspends main program for service
// - Fourth group: second serial, EEPROM, voltage detect
// - Fifth group: timers 4 and 5
// - Enabled member event sets its group flag
// - Service clears served flag and global enable
`ifndef IFB_DEFS_SVH
`define IFB_DEFS_SVH

// Register indices in the special-function area
`define IFB_REG_EDGE  4'h0
`define IFB_REG_PA    4'h1
`define IFB_REG_PB    4'h2
`define IFB_REG_PC    4'h3
`define IFB_REG_PD    4'h4
`define IFB_REG_GA    4'h5
`define IFB_REG_GE    4'h9
`define IFB_NREG      10

// Sizes
`define IFB_NPIN      4
`define IFB_NGRP      5
`define IFB_NVEC      14

// Global enable position; flags sit four above their enables, except in
// the first primary register, where the global enable pushes them to three
`define IFB_EMI_BIT   3'h0
`define IFB_FLAG_OFS  1'b1
`define IFB_FLAG_OFS_PA 3'h3

// Reset value of every register
`define IFB_RST_VAL   8'h00

// Writable bits; unimplemented bits stay zero
`define IFB_MASK_FULL 8'hff
`define IFB_MASK_PA   8'h7f
`define IFB_MASK_GAP  8'h77

// Edge select codes
`define IFB_EDGE_OFF  2'h0
`define IFB_EDGE_RISE 2'h1

`endif

// *** logic/ifb_pkg.sv ***
// Types shared by the interrupt flag and enable bank.
// Assumes the constants header is on the include path.
`include "ifb_defs.svh"

package ifb_pkg;

   // Register file of the bank
   typedef logic [`IFB_NREG-1:0][7:0] ifb_regs_t;

   // Vector positions, lowest wins
   typedef enum logic [3:0] {
      IFB_V_INT0 = 4'h0,
      IFB_V_INT1 = 4'h1,
      IFB_V_INT2 = 4'h2,
      IFB_V_INT3 = 4'h3,
      IFB_V_CP0  = 4'h4,
      IFB_V_CP1  = 4'h5,
      IFB_V_MF0  = 4'h6,
      IFB_V_MF1  = 4'h7,
      IFB_V_MF2  = 4'h8,
      IFB_V_MF3  = 4'h9,
      IFB_V_MF4  = 4'ha,
      IFB_V_ADC  = 4'hb,
      IFB_V_TB0  = 4'hc,
      IFB_V_TB1  = 4'hd
   } ifb_vec_t;

   // Peripheral request pulses, one cycle each
   typedef struct packed {
      logic [5:0] tmr_p;         // Timer P-match, timers 0..5
      logic [5:0] tmr_a;         // Timer A-match, timers 0..5
      logic       tmr1_b;        // Timer 1 B-match
      logic [1:0] cmp;           // Comparator output change
      logic       conv_done;     // A/D conversion finished
      logic [1:0] time_base;     // Time base overflow
      logic       serial;        // Serial module
      logic       second_serial; // Secondary serial port
      logic       eeprom;        // Data EEPROM
      logic       volt;          // Voltage detector
      logic       port_change;   // Port-change pin event
   } ifb_src_t;

   // Edge detector state
   typedef struct packed {
      logic [`IFB_NPIN-1:0] meta;  // First synchroniser stage
      logic [`IFB_NPIN-1:0] sync;  // Second synchroniser stage
      logic [`IFB_NPIN-1:0] last;  // Previous synchronised level
      logic [`IFB_NPIN-1:0] hit;   // Qualified edge pulse
      logic [1:0]           warm;  // Settling count after reset
   } ifb_edge_st_t;

   // Bank state
   typedef struct packed {
      ifb_regs_t  regs;     // All control registers
      logic [7:0] rdata;    // Read data
      logic       irq_req;  // Request to the core
      ifb_vec_t   irq_vec;  // Vector presented
   } ifb_state_t;

endpackage

// *** logic/ifb_edge_det.sv ***
// Pin synchroniser and edge qualifier for the external request pins.
// Assumes pins are asynchronous and selectors come from the bank.
`timescale 1ns/10ps
`include "ifb_defs.svh"

module ifb_edge_det
(
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   // Pins and edge selectors
   input  wire logic [`IFB_NPIN-1:0]    i_pins,
   input  wire logic [2*`IFB_NPIN-1:0]  i_sel,
   // Qualified edge pulses
   output logic      [`IFB_NPIN-1:0]    o_hit
);

   ifb_pkg::ifb_edge_st_t st_reg;   // Registered state
   ifb_pkg::ifb_edge_st_t st_next;  // Next state
   logic [`IFB_NPIN-1:0]  hit_w;    // Per-pin qualified edge

   ////////////////////////////////////////////////////////////////////////
   // Per-pin edge qualification; off code gives no hit
   genvar g;
   generate
      for (g = 0; g < `IFB_NPIN; g++)
      begin : g_pin
         assign hit_w[g] = (i_sel[2*g]   &  st_reg.sync[g] & ~st_reg.last[g]) |
                           (i_sel[2*g+1] & ~st_reg.sync[g] &  st_reg.last[g]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next state; the warm count hides the level seen at reset release
   always_comb
   begin
      st_next      = st_reg;
      st_next.meta = i_pins;
      st_next.sync = st_reg.meta;
      st_next.last = st_reg.sync;
      st_next.hit  = (st_reg.warm == 2'h3) ? hit_w : '0;
      if (st_reg.warm != 2'h3)
      begin
         st_next.warm = st_reg.warm + 2'h1;
      end
   end

   // State register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_hit = st_reg.hit;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_edge_off;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_sel[1:0] == `IFB_EDGE_OFF) |=> !o_hit[0];
   endproperty
   a_edge_off: assert property (p_edge_off)
      else $error("disabled pin produced an edge hit");

   property p_rise_once;
      @(posedge i_clk) disable iff (!i_rst_b)
      (st_reg.warm == 2'h3 && i_sel[1:0] == `IFB_EDGE_RISE &&
       st_reg.sync[0] && !st_reg.last[0]) |=> o_hit[0] ##1 !o_hit[0];
   endproperty
   a_rise_once: assert property (p_rise_once)
      else $error("rising edge not caught exactly once");

endmodule

// *** testbench/ifb_core_model.sv ***
// Core-side model: takes the vector that the bank presents.
// Assumes the bank holds its request until the acknowledge edge.
`timescale 1ns/10ps

module ifb_core_model
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   // Bench control: take vectors, cycles to wait first
   input  wire logic              i_take,
   input  wire logic [3:0]        i_wait,
   // Bank side
   input  wire logic              i_irq_req,
   input  wire ifb_pkg::ifb_vec_t i_irq_vec,
   output logic                   o_irq_ack,
   output ifb_pkg::ifb_vec_t      o_taken
);
   logic [3:0] wait_reg;  // Cycles the request has stood

   ////////////////////////////////////////
   // service on acknowledge
   // Ack is driven off the sampling edge and only while the request
   // stands; a slow core lets the request wait i_wait cycles first
   always @(negedge i_clk)
   begin
      if (!i_rst_b || !i_irq_req || o_irq_ack)
      begin
         o_irq_ack <= 1'b0;
         wait_reg  <= 4'h0;
      end
      else if (i_take && wait_reg >= i_wait)
      begin
         o_irq_ack <= 1'b1;
         o_taken   <= i_irq_vec;
      end
      else
      begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// *** testbench/tb_ifb_top.sv ***
// Self-checking bench of the interrupt flag and enable bank.
// Assumes the core model acknowledges; the bench drives pins and sources.
`timescale 1ns/10ps

module tb_ifb_top;
   logic              clk;         // 25 MHz clock
   logic              rst_b;       // Synchronous reset, active low
   logic [3:0]        sel;         // Register index
   logic              wr;          // Write strobe
   logic [7:0]        wdata;       // Write data
   logic [7:0]        rdata;       // Read data
   logic [3:0]        pins;        // External edge pins
   ifb_pkg::ifb_src_t src;         // Peripheral pulses
   logic              ack;         // Core acknowledge
   logic              req;         // Request to core
   ifb_pkg::ifb_vec_t vec;         // Vector presented
   ifb_pkg::ifb_vec_t taken;       // Vector the core took
   logic              take;        // Let the core take vectors
   logic [3:0]        wait_n;      // Core response delay
   int                fail_count;  // Mismatches
   int                checked;     // Comparisons
   int                cycles;      // Timeout count
   // Register and flag bit set by each source pulse, by struct bit
   logic [7:0] map_tbl [23] = '{8'h76, 8'h84, 8'h85, 8'h86, 8'h77, 8'h35, 8'h36,
      8'h27, 8'h16, 8'h24, 8'h66, 8'h55, 8'h65, 8'h57, 8'h75, 8'h95, 8'h97,
      8'h54, 8'h64, 8'h56, 8'h74, 8'h94, 8'h96};
   // Implemented bits of each register
   logic [7:0] mask_tbl [10] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'h77, 8'hff, 8'h77,
      8'hff, 8'h77, 8'hff};

   ifb_top i_ifb_top (.i_clk(clk), .i_rst_b(rst_b), .i_sfr_sel(sel), .i_sfr_wr(wr),
      .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_ext_edge_pins(pins), .i_src(src),
      .i_irq_ack(ack), .o_irq_req(req), .o_irq_vec(vec));

   ifb_core_model i_ifb_core_model (.i_clk(clk), .i_rst_b(rst_b), .i_take(take),
      .i_wait(wait_n), .i_irq_req(req), .i_irq_vec(vec), .o_irq_ack(ack),
      .o_taken(taken));

   ////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Read data lags the select by one edge
   task automatic rc(input string nm, input logic [3:0] s, input logic [7:0] exp);
      @(negedge clk);
      sel = s;
      @(negedge clk);
      chk(nm, rdata, exp);
   endtask

   task automatic wt(input logic [3:0] s, input logic [7:0] d);
      @(negedge clk);
      sel   = s;
      wdata = d;
      wr    = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic pulse(input logic [22:0] bits);
      @(negedge clk);
      src = bits;
      @(negedge clk);
      src = '0;
   endtask

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      for (int i = 0; i < 16; i++)
         rc("reset value", 4'(i), 8'h00);
   endtask

   // Unimplemented bits must stay zero; unmapped index ignores writes
   task automatic t_access();
      for (int i = 0; i < 10; i++)
      begin
         wt(4'(i), 8'hff);
         rc("mask", 4'(i), mask_tbl[i]);
         wt(4'(i), 8'h00);
         rc("clear", 4'(i), 8'h00);
      end
      wt(4'hc, 8'ha5);
      rc("unmapped", 4'hc, 8'h00);
   endtask

   // Every edge code on every pin, rise then fall
   task automatic t_edges();
      logic [3:0] r;
      logic [7:0] b;
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 4; c++)
         begin
            r = (p < 2) ? 4'h1 : 4'h4;
            b = 8'h10 << (p % 2);
            wt(4'h0, 8'(c << (2 * p)));
            pins[p] = 1'b1;
            repeat (6) @(negedge clk);
            rc("rise flag", r, c[0] ? b : 8'h00);
            wt(r, 8'h00);
            pins[p] = 1'b0;
            repeat (6) @(negedge clk);
            rc("fall flag", r, c[1] ? b : 8'h00);
            wt(r, 8'h00);
         end
   endtask

   // Each peripheral source sets its own flag; no request without global enable
   task automatic t_sources();
      for (int i = 0; i < 23; i++)
      begin
         pulse(23'h1 << i);
         rc("src flag", map_tbl[i][7:4], 8'h1 << map_tbl[i][2:0]);
         chk("req gated", {7'h0, req}, 8'h00);
         wt(map_tbl[i][7:4], 8'h00);
      end
   endtask

   // Two pending: lower vector first, slow then prompt core
   task automatic t_service();
      wt(4'h2, 8'h08);
      wt(4'h3, 8'h06);
      pulse(23'h0000c0);
      chk("req off", {7'h0, req}, 8'h00);
      wt(4'h1, 8'h01);
      repeat (2) @(negedge clk);
      chk("req on", {7'h0, req}, 8'h01);
      chk("vec", {4'h0, vec}, {4'h0, ifb_pkg::IFB_V_ADC});
      take   = 1'b1;
      wait_n = 4'h3;
      repeat (8) @(negedge clk);
      take = 1'b0;
      chk("taken", {4'h0, taken}, {4'h0, ifb_pkg::IFB_V_ADC});
      chk("req drop", {7'h0, req}, 8'h00);
      rc("global off", 4'h1, 8'h00);
      rc("adc served", 4'h2, 8'h08);
      wt(4'h1, 8'h01);
      take   = 1'b1;
      wait_n = 4'h0;
      repeat (4) @(negedge clk);
      take = 1'b0;
      chk("taken", {4'h0, taken}, {4'h0, ifb_pkg::IFB_V_TB1});
      rc("tb1 served", 4'h3, 8'h06);
      wt(4'h2, 8'h00);
      wt(4'h3, 8'h00);
   endtask

   // Group flag follows enabled members only; service leaves members set
   task automatic t_group();
      wt(4'h5, 8'h01);
      wt(4'h2, 8'h02);
      wt(4'h1, 8'h01);
      pulse(23'h020800);
      repeat (2) @(negedge clk);
      chk("grp vec", {4'h0, vec}, {4'h0, ifb_pkg::IFB_V_MF0});
      rc("members", 4'h5, 8'h31);
      rc("group", 4'h2, 8'h22);
      take = 1'b1;
      repeat (4) @(negedge clk);
      take = 1'b0;
      chk("grp taken", {4'h0, taken}, {4'h0, ifb_pkg::IFB_V_MF0});
      rc("group served", 4'h2, 8'h02);
      rc("members kept", 4'h5, 8'h31);
      wt(4'h5, 8'h01);
      pulse(23'h000800);
      rc("disabled member", 4'h2, 8'h02);
   endtask

   ////////////////////////////////////////
   // Clock, timeout and main sequence
   initial
   begin
      clk = 1'b1;
      forever #20 clk = ~clk;
   end

   // A hang counts as a mismatch
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         end_sim();
      end
   end

   initial
   begin
      rst_b  = 1'b0;
      sel    = 4'h0;
      wr     = 1'b0;
      wdata  = 8'h00;
      pins   = 4'h0;
      src    = '0;
      take   = 1'b0;
      wait_n = 4'h0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_access();
      t_edges();
      t_sources();
      t_service();
      t_group();
      end_sim();
   end
endmodule
